// ===== hrr_pkg.sv
// Shared constants and types of the hard row repair sequencer.
// Assumes a decoded command stream on the device clock and a Wishbone slave.
package hrr_pkg;

    // Decoded command opcodes
    localparam logic [2:0] HRR_OP_NONE = 3'h0;
    localparam logic [2:0] HRR_OP_MRS  = 3'h1;
    localparam logic [2:0] HRR_OP_ACT  = 3'h2;
    localparam logic [2:0] HRR_OP_WR   = 3'h3;
    localparam logic [2:0] HRR_OP_WRA  = 3'h4;
    localparam logic [2:0] HRR_OP_PRE  = 3'h5;
    localparam logic [2:0] HRR_OP_REF  = 3'h6;
    localparam logic [2:0] HRR_OP_OTH  = 3'h7;

    // Mode register select is {bg[0], ba[1:0]}
    localparam logic [2:0] HRR_MR0_SEL    = 3'h0;
    localparam logic [2:0] HRR_MR4_SEL    = 3'h4;
    localparam int         HRR_MR4_EN_BIT = 13;
    localparam int         HRR_MR4_SR_BIT = 5;

    // Guard keys: address bits 11:7, then bits 6:0 all ones
    localparam logic [4:0] HRR_KEY1      = 5'h19;
    localparam logic [4:0] HRR_KEY2      = 5'h0f;
    localparam logic [4:0] HRR_KEY3      = 5'h17;
    localparam logic [4:0] HRR_KEY4      = 5'h07;
    localparam logic [6:0] HRR_KEY_LOW   = 7'h7f;
    localparam int         HRR_KEY_COUNT = 4;

    // Burst: 4 clocks, 8 bits; all-high over the first 2 clocks means skip
    localparam int HRR_BURST_CLKS = 4;
    localparam int HRR_SKIP_CLKS  = 2;

    // Wishbone word offsets (byte addresses)
    localparam logic [3:0] HRR_REG_CTRL   = 4'h0;
    localparam logic [3:0] HRR_REG_STATUS = 4'h4;
    localparam logic [3:0] HRR_REG_TARGET = 4'h8;

    // Control field layout and reset values
    localparam int         HRR_CWL_LSB = 0;
    localparam int         HRR_AL_LSB  = 8;
    localparam int         HRR_PL_LSB  = 16;
    localparam logic [4:0] HRR_CWL_RST = 5'h09;
    localparam logic [4:0] HRR_AL_RST  = 5'h00;
    localparam logic [2:0] HRR_PL_RST  = 3'h0;

    // Status bits
    localparam int HRR_ST_ENABLED = 0;
    localparam int HRR_ST_ARMED   = 1;
    localparam int HRR_ST_DONE    = 2;
    localparam int HRR_ST_SKIPPED = 3;
    localparam int HRR_ST_UNDEF   = 4;
    localparam int HRR_ST_FAILED  = 5;
    localparam int HRR_ST_STATE   = 8;

    typedef struct packed {
        logic        valid;
        logic [2:0]  op;
        logic [1:0]  bg;
        logic [1:0]  ba;
        logic [17:0] addr;
    } hrr_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  bg;
        logic [1:0]  ba;
        logic [17:0] row;
    } hrr_target_t;

endpackage

// ===== hrr_burst_check.sv
// Qualifies the four-clock write burst of a repair request.
// Assumes rise and fall samples arrive together once per clock.
`timescale 1ns/1ns
module hrr_burst_check #(
    parameter int DQ_W = 8
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            start_i,
    input  wire logic [DQ_W-1:0] dq_rise_i,
    input  wire logic [DQ_W-1:0] dq_fall_i,
    output logic                 done_o,
    output logic                 all_low_o,
    output logic                 skip_o
);
    import hrr_pkg::*;

    logic [2:0] beat;
    logic       active;
    logic       low_ok;
    logic       high_ok;
    logic       beat_low;
    logic       beat_high;

    assign beat_low  = (dq_rise_i == '0) && (dq_fall_i == '0);
    assign beat_high = (&dq_rise_i) && (&dq_fall_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active  <= 1'b0;
            beat    <= 3'h0;
            low_ok  <= 1'b0;
            high_ok <= 1'b0;
        end else if (start_i) begin
            active  <= 1'b1;
            beat    <= 3'h1;
            low_ok  <= beat_low;
            high_ok <= beat_high;
        end else if (active) begin
            low_ok <= low_ok & beat_low;
            if (beat < 3'(HRR_SKIP_CLKS)) begin
                high_ok <= high_ok & beat_high;
            end
            beat <= beat + 3'h1;
            if (beat == 3'(HRR_BURST_CLKS - 1)) begin
                active <= 1'b0;
            end
        end
    end

    // Verdict registered on the last burst clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_o    <= 1'b0;
            all_low_o <= 1'b0;
            skip_o    <= 1'b0;
        end else begin
            done_o    <= active && (beat == 3'(HRR_BURST_CLKS - 1));
            all_low_o <= low_ok & beat_low;
            skip_o    <= high_ok;
        end
    end
endmodule

// ===== hrr_core.sv
// Hard row repair sequencer: mode enable, guard keys, repair burst, refresh masking.
// Assumes commands are decoded on the device clock and a classic Wishbone master.
// Notes on behaviour
// - Mode register four bit 13 enables hard repair; zero is normal.
// - Enabled repair mode drives every data line high, except from the write through the burst.
// - Keys have bank zero, low bits ones, fixed high-bit patterns.
// - Wrong order or interrupted keys disable repair; programming becomes no-op.
// - After interrupted entry, activate and write act as ordinary accesses.
// - Repair only if every data bit is low across the burst.
// - All-high first two clocks skips repair; other patterns undefined.
// - Autoprecharge form refreshes all banks except the repaired one.
`timescale 1ns/1ns
module hrr_core #(
    parameter int DQ_W = 8
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire hrr_pkg::hrr_cmd_t   cmd_i,
    input  wire logic [DQ_W-1:0]     dq_rise_i,
    input  wire logic [DQ_W-1:0]     dq_fall_i,
    output logic [DQ_W-1:0]          dq_o,
    output logic                     dq_oe_o,
    output logic                     normal_access_o,
    output hrr_pkg::hrr_target_t     repair_o,
    output logic                     refresh_o,
    output logic [15:0]              refresh_banks_o,
    output logic                     repair_mode_o,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [3:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o
);
    import hrr_pkg::*;

    typedef enum logic [7:0] {
        S_IDLE   = 8'h01,
        S_KEYS   = 8'h02,
        S_ARMED  = 8'h04,
        S_OPEN   = 8'h08,
        S_LAT    = 8'h10,
        S_BURST  = 8'h20,
        S_PROG   = 8'h40,
        S_FAILED = 8'h80
    } hrr_state_t;

    hrr_state_t  state;
    hrr_state_t  next_state;
    logic [1:0]  key_idx;
    logic [4:0]  key_exp;
    logic [4:0]  column_write_latency;
    logic [4:0]  al;
    logic [2:0]  pl;
    logic [6:0]  wl_cnt;
    logic [6:0]  write_latency;
    logic        wra_form;
    logic        st_done;
    logic        st_skipped;
    logic        st_undef;
    logic        st_failed;
    logic        burst_done;
    logic        burst_low;
    logic        burst_skip;
    logic        burst_start;
    logic        is_mrs;
    logic [2:0]  mr_sel;
    logic        mr4_write;
    logic        key_match;
    logic        same_bank;
    logic        wb_req;
    logic        clr_done;
    logic        clr_skip;
    logic        clr_undef;
    logic        clr_fail;

    assign write_latency = 7'(column_write_latency) + 7'(al) + 7'(pl);
    assign is_mrs    = cmd_i.valid && (cmd_i.op == HRR_OP_MRS);
    assign mr_sel    = {cmd_i.bg[0], cmd_i.ba};
    assign mr4_write = is_mrs && (mr_sel == HRR_MR4_SEL);
    assign same_bank = (cmd_i.bg == repair_o.bg) && (cmd_i.ba == repair_o.ba);

    always_comb begin
        case (key_idx)
            2'h0:    key_exp = HRR_KEY1;
            2'h1:    key_exp = HRR_KEY2;
            2'h2:    key_exp = HRR_KEY3;
            default: key_exp = HRR_KEY4;
        endcase
    end

    assign key_match = is_mrs && (cmd_i.bg == 2'h0) && (cmd_i.ba == 2'h0)
                    && (cmd_i.addr[11:7] == key_exp) && (cmd_i.addr[6:0] == HRR_KEY_LOW);

    assign burst_start = (state == S_LAT) && (wl_cnt <= 7'h1);

    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (mr4_write && cmd_i.addr[HRR_MR4_EN_BIT]) begin
                    next_state = S_KEYS;
                end
            end
            S_KEYS: begin
                if (cmd_i.valid && !key_match) begin
                    next_state = S_FAILED;
                end else if (key_match && key_idx == 2'(HRR_KEY_COUNT - 1)) begin
                    next_state = S_ARMED;
                end
            end
            S_ARMED: begin
                if (cmd_i.valid && cmd_i.op == HRR_OP_ACT) begin
                    next_state = S_OPEN;
                end
            end
            S_OPEN: begin
                if (cmd_i.valid && same_bank
                    && (cmd_i.op == HRR_OP_WR || cmd_i.op == HRR_OP_WRA)) begin
                    next_state = S_LAT;
                end
            end
            S_LAT: begin
                if (burst_start) begin
                    next_state = S_BURST;
                end
            end
            S_BURST: begin
                if (burst_done) begin
                    next_state = S_PROG;
                end
            end
            S_PROG,
            S_FAILED: begin
                next_state = state;
            end
            default: next_state = S_IDLE;
        endcase
        // clearing the bit leaves the mode from any state
        if (mr4_write && !cmd_i.addr[HRR_MR4_EN_BIT]) begin
            next_state = S_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // key counter, restarted on every enable
    always_ff @(posedge clk_i) begin
        if (rst_i || state != S_KEYS) begin
            key_idx <= 2'h0;
        end else if (key_match) begin
            key_idx <= key_idx + 2'h1;
        end
    end

    // Target capture on activate, form captured on the write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            repair_o <= '0;
            wra_form <= 1'b0;
        end else begin
            repair_o.valid <= 1'b0;
            if (state == S_ARMED && cmd_i.valid && cmd_i.op == HRR_OP_ACT) begin
                repair_o.bg  <= cmd_i.bg;
                repair_o.ba  <= cmd_i.ba;
                repair_o.row <= cmd_i.addr;
            end
            if (state == S_OPEN && next_state == S_LAT) begin
                wra_form <= (cmd_i.op == HRR_OP_WRA);
            end
            // repair only on an all-low burst
            if (state == S_BURST && burst_done && burst_low) begin
                repair_o.valid <= 1'b1;
            end
        end
    end

    // data arrives one write latency after the write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wl_cnt <= 7'h0;
        end else if (state == S_OPEN && next_state == S_LAT) begin
            wl_cnt <= write_latency;
        end else if (state == S_LAT && wl_cnt != 7'h0) begin
            wl_cnt <= wl_cnt - 7'h1;
        end
    end

    hrr_burst_check #(
        .DQ_W (DQ_W)
    ) u_burst (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .start_i   (burst_start),
        .dq_rise_i (dq_rise_i),
        .dq_fall_i (dq_fall_i),
        .done_o    (burst_done),
        .all_low_o (burst_low),
        .skip_o    (burst_skip)
    );

    // all data lines driven high except from the write until the burst is taken in
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dq_o    <= '0;
            dq_oe_o <= 1'b0;
        end else begin
            dq_o    <= '1;
            dq_oe_o <= (next_state != S_IDLE) && (next_state != S_LAT)
                    && (next_state != S_BURST);
        end
    end

    // after failed entry activates and writes are ordinary accesses
    assign normal_access_o = cmd_i.valid && (state == S_IDLE || state == S_FAILED)
                          && (cmd_i.op == HRR_OP_ACT || cmd_i.op == HRR_OP_WR
                              || cmd_i.op == HRR_OP_WRA);
    assign repair_mode_o = (state != S_IDLE);

    // refresh spares the bank under repair; plain write form ignores it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            refresh_o       <= 1'b0;
            refresh_banks_o <= 16'h0000;
        end else begin
            refresh_o       <= 1'b0;
            refresh_banks_o <= 16'h0000;
            if (cmd_i.valid && cmd_i.op == HRR_OP_REF) begin
                if (state == S_IDLE || state == S_FAILED) begin
                    refresh_o       <= 1'b1;
                    refresh_banks_o <= 16'hffff;
                end else if (state == S_PROG && wra_form) begin
                    refresh_o       <= 1'b1;
                    refresh_banks_o <= ~(16'h0001 << {repair_o.bg, repair_o.ba});
                end
            end
        end
    end

    // Wishbone slave: ack one cycle after the request, dropped the next cycle
    assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign clr_done  = wb_req && wb_we_i && (wb_adr_i == HRR_REG_STATUS)
                    && wb_sel_i[0] && wb_dat_i[HRR_ST_DONE];
    assign clr_skip  = wb_req && wb_we_i && (wb_adr_i == HRR_REG_STATUS)
                    && wb_sel_i[0] && wb_dat_i[HRR_ST_SKIPPED];
    assign clr_undef = wb_req && wb_we_i && (wb_adr_i == HRR_REG_STATUS)
                    && wb_sel_i[0] && wb_dat_i[HRR_ST_UNDEF];
    assign clr_fail  = wb_req && wb_we_i && (wb_adr_i == HRR_REG_STATUS)
                    && wb_sel_i[0] && wb_dat_i[HRR_ST_FAILED];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            column_write_latency <= HRR_CWL_RST;
            al  <= HRR_AL_RST;
            pl  <= HRR_PL_RST;
        end else if (wb_req && wb_we_i && wb_adr_i == HRR_REG_CTRL) begin
            if (wb_sel_i[0]) begin
                column_write_latency <= wb_dat_i[HRR_CWL_LSB +: 5];
            end
            if (wb_sel_i[1]) begin
                al <= wb_dat_i[HRR_AL_LSB +: 5];
            end
            if (wb_sel_i[2]) begin
                pl <= wb_dat_i[HRR_PL_LSB +: 3];
            end
        end
    end

    // Sticky outcome flags, write one to clear; a new event wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_done    <= 1'b0;
            st_skipped <= 1'b0;
            st_undef   <= 1'b0;
            st_failed  <= 1'b0;
        end else begin
            // skip on all-high lead, undefined on mixed data
            st_done    <= (state == S_BURST && burst_done && burst_low)
                       || (st_done && !clr_done);
            st_skipped <= (state == S_BURST && burst_done && !burst_low && burst_skip)
                       || (st_skipped && !clr_skip);
            st_undef   <= (state == S_BURST && burst_done && !burst_low && !burst_skip)
                       || (st_undef && !clr_undef);
            st_failed  <= (state == S_KEYS && next_state == S_FAILED)
                       || (st_failed && !clr_fail);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                HRR_REG_CTRL:   wb_dat_o <= {13'h0000, pl, 3'h0, al, 3'h0, column_write_latency};
                HRR_REG_STATUS: wb_dat_o <= {16'h0000, state, 2'h0, st_failed, st_undef,
                                             st_skipped, st_done,
                                             (state == S_ARMED), repair_mode_o};
                HRR_REG_TARGET: wb_dat_o <= {10'h000, repair_o.bg, repair_o.ba, repair_o.row};
                default:        wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ===== hrr_core_assertions.sv
// Checker of the repair sequencer, watching top ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module hrr_core_assertions
    import hrr_pkg::*;
#(
    parameter int DQ_W = 8
) (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire hrr_pkg::hrr_cmd_t    cmd_i,
    input wire logic [DQ_W-1:0]      dq_rise_i,
    input wire logic [DQ_W-1:0]      dq_fall_i,
    input wire logic [DQ_W-1:0]      dq_o,
    input wire logic                 dq_oe_o,
    input wire logic                 normal_access_o,
    input wire hrr_pkg::hrr_target_t repair_o,
    input wire logic                 refresh_o,
    input wire logic [15:0]          refresh_banks_o,
    input wire logic                 repair_mode_o,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_ack_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       mr4_wr;
    logic       acc_cmd;
    logic [3:0] lows;
    assign mr4_wr = cmd_i.valid && cmd_i.op == HRR_OP_MRS && {cmd_i.bg[0], cmd_i.ba} == HRR_MR4_SEL;
    assign acc_cmd = cmd_i.valid && cmd_i.op inside {HRR_OP_ACT, HRR_OP_WR, HRR_OP_WRA};
    // Low samples since entry; a repair needs a whole low burst first
    always_ff @(posedge clk_i) begin
        if (rst_i || !repair_mode_o) begin
            lows <= 4'h0;
        end else if (dq_rise_i == '0 && dq_fall_i == '0 && lows != 4'hf) begin
            lows <= lows + 4'h1;
        end
    end
    a_mode_enable: assert property (mr4_wr && cmd_i.addr[13] && !repair_mode_o |=>
        repair_mode_o ##[0:1] dq_oe_o) else $error("mode or line drive missing");
    a_mode_exit: assert property (mr4_wr && !cmd_i.addr[13] |=> !repair_mode_o)
        else $error("mode still on after clear");
    a_lines_high: assert property (dq_oe_o |-> dq_o == '1)
        else $error("driven lines not all high");
    a_normal_idle: assert property (acc_cmd && !repair_mode_o |-> normal_access_o)
        else $error("idle access not ordinary");
    a_normal_cause: assert property (normal_access_o |-> acc_cmd)
        else $error("ordinary access without command");
    a_repair_low: assert property (repair_o.valid |-> repair_mode_o && lows >= 4'h4)
        else $error("repair without low burst");
    a_refresh_cause: assert property (refresh_o |-> $past(cmd_i.valid && cmd_i.op == HRR_OP_REF))
        else $error("refresh without command");
    a_refresh_mask: assert property (refresh_o && repair_mode_o |->
        !refresh_banks_o[{repair_o.bg, repair_o.ba}]) else $error("repaired bank refreshed");
    a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer late or long");
    c_repair: cover property (repair_o.valid);
    c_refresh: cover property (refresh_o && repair_mode_o);
    c_normal: cover property (normal_access_o && repair_mode_o);
endmodule

// ===== hrr_ctrl_model.sv
// Memory-controller model driving decoded commands and burst lines.
// Assumes the block samples both on the rising clock edge.
`timescale 1ns/1ns
module hrr_ctrl_model
    import hrr_pkg::*;
#(
    parameter int DQ_W = 8
) (
    input  wire logic           clk_i,
    output hrr_pkg::hrr_cmd_t   cmd_o,
    output logic [DQ_W-1:0]     dq_rise_o,
    output logic [DQ_W-1:0]     dq_fall_o
);
    localparam logic [4:0] KEYS [4] = '{HRR_KEY1, HRR_KEY2, HRR_KEY3, HRR_KEY4};
    int              b_cnt = 0;
    logic [1:0]      b_kind = 2'h0;
    logic [DQ_W-1:0] b_val;
    initial cmd_o = '0;
    initial dq_rise_o = {(DQ_W/2){2'b10}};
    initial dq_fall_o = {(DQ_W/2){2'b01}};
    // burst one write latency after the write
    // Outside bursts the lines toggle and are never all low or all high
    always @(posedge clk_i) begin
        if (b_cnt >= 2 && b_cnt <= 5) begin
            b_val = (b_kind == 2'h1) ? '1 : ((b_kind == 2'h2 && b_cnt == 5) ? DQ_W'(1) : '0);
            dq_rise_o <= b_val;
            dq_fall_o <= b_val;
        end else begin
            dq_rise_o <= (dq_rise_o == '0 || dq_rise_o == '1) ? {(DQ_W/2){2'b10}} : ~dq_rise_o;
            dq_fall_o <= (dq_rise_o == '0 || dq_rise_o == '1) ? {(DQ_W/2){2'b01}} : dq_rise_o;
        end
        if (b_cnt != 0) begin
            b_cnt <= b_cnt - 1;
        end
    end
    // one listed command, idle cycle after it
    task issue(input logic [2:0] op, input logic [1:0] bg, input logic [1:0] ba,
               input logic [17:0] addr);
        @(posedge clk_i);
        cmd_o <= '{1'b1, op, bg, ba, addr};
        @(posedge clk_i);
        cmd_o.valid <= 1'b0;
    endtask
    // guard key to mode register zero
    task key(input int k);
        issue(HRR_OP_MRS, 2'h0, 2'h0, {6'h0, KEYS[k], HRR_KEY_LOW});
    endtask
    // Called on the edge that takes the write; needs a latency of two or more
    task burst(input logic [1:0] kind, input int wl);
        b_kind <= kind;
        b_cnt <= wl + 3;
    endtask
endmodule

// ===== test_hrr_core.sv
// Self-checking bench of the repair sequencer with a controller model.
// Assumes the checker and the model are compiled before it.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); err_total++; end end
module test_hrr_core;
    import hrr_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    hrr_cmd_t    cmd_i;
    logic [7:0]  dq_rise_i;
    logic [7:0]  dq_fall_i;
    logic [7:0]  dq_o;
    logic        dq_oe_o;
    logic        normal_access_o;
    hrr_target_t repair_o;
    logic        refresh_o;
    logic [15:0] refresh_banks_o;
    logic        repair_mode_o;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    int          err_total = 0;
    int          samples_checked = 0;
    int          norm_seen = 0;
    int          wl;
    logic [4:0]  column_write_latency;
    logic [4:0]  al;
    logic [2:0]  pl;
    logic [63:0] rd_q[$];
    hrr_target_t rep_q[$];
    logic [16:0] ref_q[$];
    hrr_core #(.DQ_W(8)) hrr_core_i (.clk_i, .rst_i, .cmd_i, .dq_rise_i, .dq_fall_i, .dq_o,
        .dq_oe_o, .normal_access_o, .repair_o, .refresh_o, .refresh_banks_o, .repair_mode_o,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
    hrr_ctrl_model #(.DQ_W(8)) hrr_ctrl_model_i (.clk_i, .cmd_o(cmd_i),
        .dq_rise_o(dq_rise_i), .dq_fall_o(dq_fall_i));
    initial forever #10 clk_i = ~clk_i;
    task complete_run();
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Reads note {mask, expected} before the request goes out
    task wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
            input logic [3:0] sel, input logic [31:0] mask);
        int n;
        if (!we) rd_q.push_back({mask, dat & mask});
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= we ? dat : 32'h0;
        n = 0;
        do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
        `CHK("wb_ack_o", 1'b1, wb_ack_o)
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // An unexpected result meets an empty queue and a mismatching stand-in
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            rd_q.push_front(64'h1);
            rd_q.delete(rd_q.size() > 1 ? 0 : 1);
            `CHK("wb_dat_o", rd_q[0][31:0], wb_dat_o & rd_q[0][63:32])
            void'(rd_q.pop_front());
        end
        if (repair_o.valid === 1'b1) begin
            `CHK("repair_o", rep_q.size() ? rep_q.pop_front() : '0, repair_o)
        end
        if (refresh_o === 1'b1) begin
            `CHK("refresh", ref_q.size() ? ref_q.pop_front() : 17'h0, {refresh_o, refresh_banks_o})
        end
        if (normal_access_o === 1'b1) norm_seen++;
    end
    task automatic flow(input logic write_with_autoprecharge, input logic [1:0] pat, input logic bad);
        logic [1:0]  bg = 2'($urandom_range(3, 0));
        logic [1:0]  ba = 2'($urandom_range(3, 0));
        logic [17:0] row = 18'($urandom());
        int          n0 = norm_seen;
        // entry with soft repair bit clear, nothing else on
        hrr_ctrl_model_i.issue(HRR_OP_MRS, 2'h1, 2'h0, 18'h2000);
        for (int k = 0; k < HRR_KEY_COUNT; k++) hrr_ctrl_model_i.key(bad && k < 2 ? 1 - k : k);
        hrr_ctrl_model_i.issue(HRR_OP_ACT, bg, ba, row);
        if (!bad && pat == 2'h0) rep_q.push_back('{1'b1, bg, ba, row});
        hrr_ctrl_model_i.issue(write_with_autoprecharge ? HRR_OP_WRA : HRR_OP_WR, bg, ba, 18'h0);
        hrr_ctrl_model_i.burst(pat, wl);
        // refresh well after write recovery; ignored in the plain form
        repeat (wl + 8) @(posedge clk_i);
        if (!bad && pat == 2'h0) begin
            if (write_with_autoprecharge) ref_q.push_back({1'b1, ~(16'h1 << {bg, ba})});
            hrr_ctrl_model_i.issue(HRR_OP_REF, 2'h0, 2'h0, 18'h0);
            wb(1'b0, HRR_REG_TARGET, {10'h0, bg, ba, row}, 4'hf, 32'h003fffff);
        end
        wb(1'b0, HRR_REG_STATUS, {26'h0, bad, !bad && pat == 2, !bad && pat == 1,
            !bad && pat == 0, 2'h0}, 4'hf, 32'h3c);
        wb(1'b1, HRR_REG_STATUS, 32'h3c, 4'h1, 32'h0);
        `CHK("normal_access_o", bad ? 2 : 0, norm_seen - n0)
        // Program time scaled down; the idle cycle after it covers the exit wait
        hrr_ctrl_model_i.issue(HRR_OP_PRE, bg, ba, 18'h0);
        // exit, then mode register zero restored
        hrr_ctrl_model_i.issue(HRR_OP_MRS, 2'h1, 2'h0, 18'h0);
        @(negedge clk_i);
        `CHK("repair_mode_o", 1'b0, repair_mode_o)
        hrr_ctrl_model_i.issue(HRR_OP_MRS, 2'h0, 2'h0, 18'h0);
        // readback access after exit is an ordinary access
        hrr_ctrl_model_i.issue(HRR_OP_ACT, bg, ba, row);
        hrr_ctrl_model_i.issue(HRR_OP_WR, bg, ba, 18'h0);
        @(negedge clk_i);
        `CHK("readback_access", bad ? 4 : 2, norm_seen - n0)
    endtask
    initial begin
        void'($urandom(32'h4ced0504));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, HRR_REG_CTRL, {13'h0, HRR_PL_RST, 3'h0, HRR_AL_RST, 3'h0, HRR_CWL_RST}, 4'hf,
            32'h00071f1f);
        wb(1'b0, 4'hc, 32'h0, 4'hf, 32'hffffffff);
        column_write_latency = 5'($urandom_range(5, 2));
        al = 5'($urandom_range(2, 0));
        pl = 3'($urandom_range(1, 0));
        wl = column_write_latency + al + pl;
        wb(1'b1, HRR_REG_CTRL, {13'h0, pl, 3'h0, al, 3'h0, column_write_latency}, 4'h7, 32'h0);
        wb(1'b0, HRR_REG_CTRL, {13'h0, pl, 3'h0, al, 3'h0, column_write_latency}, 4'hf, 32'h00071f1f);
        flow(1'b1, 2'h0, 1'b0);
        flow(1'b0, 2'h0, 1'b0);
        flow(1'b1, 2'h1, 1'b0);
        flow(1'b0, 2'h2, 1'b0);
        flow(1'b1, 2'h0, 1'b1);
        repeat (4) @(posedge clk_i);
        `CHK("pending", 0, rd_q.size() + rep_q.size() + ref_q.size())
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        complete_run();
    end
endmodule
bind hrr_core hrr_core_assertions #(.DQ_W(DQ_W)) hrr_core_assertions_i (.clk_i, .rst_i,
    .cmd_i, .dq_rise_i, .dq_fall_i, .dq_o, .dq_oe_o, .normal_access_o, .repair_o, .refresh_o,
    .refresh_banks_o, .repair_mode_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
